// file: dpr_cfg.svh
// constants for the dual-port ram block
`ifndef DPR_CFG_SVH
`define DPR_CFG_SVH

`define DPR_ADDR_W    6
`define DPR_DATA_W    8
`define DPR_NIB_W     4
`define DPR_WORDS     32
`define DPR_IDX_W     5
`define DPR_TOP_BIT   5
`define DPR_NIB_BIT   0
`define DPR_RDATA_RST 8'h00
`define DPR_NIB_ZERO  4'h0
`define DPR_TOP_MASK  6'h20

`endif

// file: dpr_edge.sv
// port clock synchroniser with selectable active edge
`timescale 1ns/1ps

module dpr_edge
(
	// system
	input  wire logic clk,
	input  wire logic reset_n,
	// port clock pin and its polarity
	input  wire logic port_clk,
	input  wire logic falling_sel,
	// one-cycle pulse on the active edge
	output logic      fire
);

	logic sync1;
	logic sync2;
	logic prev;

	// two-stage synchroniser, then one stage for edge detection
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			prev  <= 1'b0;
		end
		else
		begin
			sync1 <= port_clk;
			sync2 <= sync1;
			prev  <= sync2;
		end
	end

	// same detector for both edges, only the sense is swapped
	always_comb
	begin
		fire = (sync2 != prev) && (sync2 == !falling_sel);
	end

	// the pulse must trace back to the pin level two and three cycles earlier
	a_edge_sense: assert property (@(posedge clk) disable iff (!reset_n)
		fire |-> (sync2 == !falling_sel) && (sync2 == $past(port_clk, 2))
			&& (prev == $past(port_clk, 3)))
		else $error("edge pulse does not follow the port clock pin");

	a_edge_single: assert property (@(posedge clk) disable iff (!reset_n)
		fire |=> !fire)
		else $error("edge pulse longer than one cycle");

endmodule : dpr_edge

// file: dpr_pkg.sv
// types shared by the dual-port ram block
`include "dpr_cfg.svh"

package dpr_pkg;

	// one write request as seen on the write side
	typedef struct packed {
		logic                      en;
		logic [`DPR_ADDR_W-1:0]    addr;
		logic [`DPR_DATA_W-1:0]    data;
	} dpr_wreq_t;

	// one read request as seen on the read side
	typedef struct packed {
		logic                      en;
		logic [`DPR_ADDR_W-1:0]    addr;
	} dpr_rreq_t;

	// static configuration of the block
	typedef struct packed {
		logic                      byte_mode;
		logic                      wr_fall;
		logic                      rd_fall;
	} dpr_cfg_t;

endpackage : dpr_pkg

// file: dpr_sram.sv
// dual-port 256-bit ram block, 32x8 or 64x4
// Functional notes
// - 256 bits of storage, usable as 32 bytes or 64 nibbles.
// - read and write ports run independently and never block each other.
// - each port takes a six-bit word address, 64 words in nibble mode.
// - in byte mode the top address bit of both ports is ignored.
// - separate read and write clocks, each with selectable active edge.
// - falling-edge write behaves exactly like rising-edge write.
// - eight-bit write and read buses; nibble mode uses the low half.
`timescale 1ns/1ps
`include "dpr_cfg.svh"

module dpr_sram
	import dpr_pkg::*;
(
	// system
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	// configuration
	input  wire logic                   byte_mode,
	input  wire logic                   write_clk_falling,
	input  wire logic                   read_clk_falling,
	// write port
	input  wire logic                   write_clk,
	input  wire logic                   write_en,
	input  wire logic [`DPR_ADDR_W-1:0] write_word_addr,
	input  wire logic [`DPR_DATA_W-1:0] write_data_in,
	// read port
	input  wire logic                   read_clk,
	input  wire logic                   read_en,
	input  wire logic [`DPR_ADDR_W-1:0] read_word_addr,
	output logic      [`DPR_DATA_W-1:0] read_data_out
);

	// storage: 32 bytes, a nibble word is one half of a byte
	logic [`DPR_DATA_W-1:0] mem [`DPR_WORDS];

	dpr_cfg_t  cfg_s1;
	dpr_cfg_t  cfg;
	dpr_wreq_t wreq_s1;
	dpr_wreq_t wreq;
	dpr_rreq_t rreq_s1;
	dpr_rreq_t rreq;
	logic      write_fire;
	logic      read_fire;
	logic [`DPR_IDX_W-1:0] w_idx;
	logic [`DPR_IDX_W-1:0] r_idx;

	// byte index of a port address; the top bit is dropped in byte mode
	function automatic logic [`DPR_IDX_W-1:0] word_index(
		input logic [`DPR_ADDR_W-1:0] addr,
		input logic                   bmode
	);
		if (bmode)
			word_index = addr[`DPR_IDX_W-1:0];
		else
			word_index = addr[`DPR_ADDR_W-1:1];
	endfunction : word_index

	// value a read returns from a stored byte
	function automatic logic [`DPR_DATA_W-1:0] read_value(
		input logic [`DPR_DATA_W-1:0] word,
		input logic                   nib_hi,
		input logic                   bmode
	);
		if (bmode)
			read_value = word;
		else if (nib_hi)
			read_value = {`DPR_NIB_ZERO, word[`DPR_DATA_W-1:`DPR_NIB_W]};
		else
			read_value = {`DPR_NIB_ZERO, word[`DPR_NIB_W-1:0]};
	endfunction : read_value

	// configuration arrives from the array, two flip-flops before use
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cfg_s1 <= '0;
			cfg    <= '0;
		end
		else
		begin
			cfg_s1 <= '{byte_mode: byte_mode, wr_fall: write_clk_falling,
				rd_fall: read_clk_falling};
			cfg    <= cfg_s1;
		end
	end

	// write request pins, aligned with the write clock synchroniser
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wreq_s1 <= '0;
			wreq    <= '0;
		end
		else
		begin
			wreq_s1 <= '{en: write_en, addr: write_word_addr, data: write_data_in};
			wreq    <= wreq_s1;
		end
	end

	// read request pins, aligned with the read clock synchroniser
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rreq_s1 <= '0;
			rreq    <= '0;
		end
		else
		begin
			rreq_s1 <= '{en: read_en, addr: read_word_addr};
			rreq    <= rreq_s1;
		end
	end

	// separate edge detectors per port
	dpr_edge u_wr_edge
	(
		.clk         (clk),
		.reset_n     (reset_n),
		.port_clk    (write_clk),
		.falling_sel (cfg.wr_fall),
		.fire        (write_fire)
	);

	dpr_edge u_rd_edge
	(
		.clk         (clk),
		.reset_n     (reset_n),
		.port_clk    (read_clk),
		.falling_sel (cfg.rd_fall),
		.fire        (read_fire)
	);

	// address decode for both ports
	always_comb
	begin
		w_idx = word_index(wreq.addr, cfg.byte_mode);
		r_idx = word_index(rreq.addr, cfg.byte_mode);
	end

	// write port: whole byte, or one nibble chosen by the low address bit
	always_ff @(posedge clk)
	begin
		if (write_fire && wreq.en)
		begin
			if (cfg.byte_mode)
				mem[w_idx] <= wreq.data;
			else if (wreq.addr[`DPR_NIB_BIT])
				mem[w_idx][`DPR_DATA_W-1:`DPR_NIB_W] <= wreq.data[`DPR_NIB_W-1:0];
			else
				mem[w_idx][`DPR_NIB_W-1:0] <= wreq.data[`DPR_NIB_W-1:0];
		end
	end

	// read port: own edge, own address, never waits for the write port
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			read_data_out <= `DPR_RDATA_RST;
		else if (read_fire && rreq.en)
			read_data_out <= read_value(mem[r_idx], rreq.addr[`DPR_NIB_BIT],
				cfg.byte_mode);
	end

	// checks on the storage and both ports

	a_byte_write_lands: assert property (@(posedge clk) disable iff (!reset_n)
		(write_fire && wreq.en && cfg.byte_mode) |=>
			(mem[$past(w_idx)] == $past(wreq.data)))
		else $error("byte write not stored at addressed word");

	a_nib_write_keeps: assert property (@(posedge clk) disable iff (!reset_n)
		(write_fire && wreq.en && !cfg.byte_mode && !wreq.addr[`DPR_NIB_BIT]) |=>
			(mem[$past(w_idx)][`DPR_NIB_W-1:0] == $past(wreq.data[`DPR_NIB_W-1:0]))
			&& (mem[$past(w_idx)][`DPR_DATA_W-1:`DPR_NIB_W] ==
			$past(mem[w_idx][`DPR_DATA_W-1:`DPR_NIB_W])))
		else $error("low nibble write wrong or upper nibble disturbed");

	a_read_returns: assert property (@(posedge clk) disable iff (!reset_n)
		(read_fire && rreq.en && cfg.byte_mode) |=>
			(read_data_out == $past(mem[r_idx])))
		else $error("read output does not match addressed word");

	// nibble read: low half carries the nibble picked by the low address bit
	a_nib_read_low: assert property (@(posedge clk) disable iff (!reset_n)
		(read_fire && rreq.en && !cfg.byte_mode) |=>
			(read_data_out[`DPR_NIB_W-1:0] == ($past(rreq.addr[`DPR_NIB_BIT]) ?
			$past(mem[r_idx][`DPR_DATA_W-1:`DPR_NIB_W]) :
			$past(mem[r_idx][`DPR_NIB_W-1:0]))))
		else $error("nibble read returns the wrong half");

	// upper nibble write must leave the lower nibble alone
	a_nib_write_high: assert property (@(posedge clk) disable iff (!reset_n)
		(write_fire && wreq.en && !cfg.byte_mode && wreq.addr[`DPR_NIB_BIT]) |=>
			(mem[$past(w_idx)][`DPR_DATA_W-1:`DPR_NIB_W] == $past(wreq.data[`DPR_NIB_W-1:0]))
			&& (mem[$past(w_idx)][`DPR_NIB_W-1:0] == $past(mem[w_idx][`DPR_NIB_W-1:0])))
		else $error("upper nibble write wrong or lower nibble disturbed");

	// an edge with the enable low must not touch the addressed word
	a_write_refused: assert property (@(posedge clk) disable iff (!reset_n)
		(write_fire && !wreq.en) |=> (mem[$past(w_idx)] == $past(mem[w_idx])))
		else $error("disabled write changed the addressed word");

	a_read_holds: assert property (@(posedge clk) disable iff (!reset_n)
		!(read_fire && rreq.en) |=> $stable(read_data_out))
		else $error("read output changed without an active read edge");

	a_nib_upper_zero: assert property (@(posedge clk) disable iff (!reset_n)
		(read_fire && rreq.en && !cfg.byte_mode) |=>
			(read_data_out[`DPR_DATA_W-1:`DPR_NIB_W] == `DPR_NIB_ZERO))
		else $error("upper half of read bus not zero in nibble mode");

	a_top_bit_ignored: assert property (@(posedge clk) disable iff (!reset_n)
		cfg.byte_mode |-> (r_idx == rreq.addr[`DPR_IDX_W-1:0])
			&& (w_idx == wreq.addr[`DPR_IDX_W-1:0]))
		else $error("top address bit affects byte mode decode");

	a_ports_concurrent: assert property (@(posedge clk) disable iff (!reset_n)
		(read_fire && rreq.en && write_fire && wreq.en && cfg.byte_mode) |=>
			(read_data_out == $past(mem[r_idx]))
			&& (mem[$past(w_idx)] == $past(wreq.data)))
		else $error("simultaneous read and write interfered");

endmodule : dpr_sram

// file: dpr_user_model.sv
// far-side user logic model that drives the write and read ports
`timescale 1ns/1ps
`include "dpr_cfg.svh"

module dpr_user_model
(
	// system
	input  wire logic                   clk,
	// write port
	output logic                        write_clk,
	output logic                        write_en,
	output logic      [`DPR_ADDR_W-1:0] write_word_addr,
	output logic      [`DPR_DATA_W-1:0] write_data_in,
	// read port
	output logic                        read_clk,
	output logic                        read_en,
	output logic      [`DPR_ADDR_W-1:0] read_word_addr
);
	// idle state: port clocks low, enables low
	initial
	begin
		write_clk       = 1'b0;
		write_en        = 1'b0;
		write_word_addr = '0;
		write_data_in   = '0;
		read_clk        = 1'b0;
		read_en         = 1'b0;
		read_word_addr  = '0;
	end

	// one full write clock period; request held around both edges
	// so either polarity sees it stable for several system cycles
	task automatic wr_op(input logic en, input logic [`DPR_ADDR_W-1:0] a,
		input logic [`DPR_DATA_W-1:0] d);
		@(negedge clk);
		write_en        = en;
		write_word_addr = a;
		write_data_in   = d;
		repeat (4) @(negedge clk);
		write_clk = 1'b1;
		repeat (4) @(negedge clk);
		write_clk = 1'b0;
		repeat (4) @(negedge clk);
		// released lines change instead of keeping the last value
		write_en        = 1'b0;
		write_word_addr = ~a;
		write_data_in   = ~d;
	endtask : wr_op

	// one full read clock period, same shape as a write
	task automatic rd_op(input logic en, input logic [`DPR_ADDR_W-1:0] a);
		@(negedge clk);
		read_en        = en;
		read_word_addr = a;
		repeat (4) @(negedge clk);
		read_clk = 1'b1;
		repeat (4) @(negedge clk);
		read_clk = 1'b0;
		repeat (4) @(negedge clk);
		read_en        = 1'b0;
		read_word_addr = ~a;
	endtask : rd_op
endmodule : dpr_user_model

// file: dual_port_sram_block_tb_top.sv
// self-checking bench for the dual-port ram block
`timescale 1ns/1ps
`include "dpr_cfg.svh"

module dual_port_sram_block_tb_top
	import dpr_pkg::*;
;
	logic                   clk;
	logic                   reset_n;
	dpr_cfg_t               cfg;
	logic                   wclk;
	logic                   wen;
	logic [`DPR_ADDR_W-1:0] waddr;
	logic [`DPR_DATA_W-1:0] wdata;
	logic                   rclk;
	logic                   ren;
	logic [`DPR_ADDR_W-1:0] raddr;
	logic [`DPR_DATA_W-1:0] rdata;
	logic [`DPR_DATA_W-1:0] ref_mem [`DPR_WORDS];
	logic [`DPR_DATA_W-1:0] last_rd;
	logic [`DPR_DATA_W-1:0] rdata_hi;
	logic [`DPR_DATA_W-1:0] last_hi;
	logic [31:0]            seed;
	int                     n_errors;
	int                     checked;

	// 100 MHz system clock
	initial clk = 1'b0;
	always #5 clk = ~clk;

	dpr_user_model u_user (.clk(clk), .write_clk(wclk), .write_en(wen),
		.write_word_addr(waddr), .write_data_in(wdata), .read_clk(rclk),
		.read_en(ren), .read_word_addr(raddr));

	dpr_sram dut (.clk(clk), .reset_n(reset_n), .byte_mode(cfg.byte_mode),
		.write_clk_falling(cfg.wr_fall), .read_clk_falling(cfg.rd_fall),
		.write_clk(wclk), .write_en(wen), .write_word_addr(waddr),
		.write_data_in(wdata), .read_clk(rclk), .read_en(ren),
		.read_word_addr(raddr), .read_data_out(rdata));

	// second block beside the first widens the word to sixteen bits in byte mode, eight in nibble mode
	dpr_sram dut_hi (.clk(clk), .reset_n(reset_n), .byte_mode(cfg.byte_mode),
		.write_clk_falling(cfg.wr_fall), .read_clk_falling(cfg.rd_fall),
		.write_clk(wclk), .write_en(wen), .write_word_addr(waddr),
		.write_data_in(~wdata), .read_clk(rclk), .read_en(ren),
		.read_word_addr(raddr), .read_data_out(rdata_hi));

	// pseudo-random source
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// expected read value: byte mode drops bit 5, nibble mode zeroes the top half
	function automatic logic [7:0] expect_rd(input logic [5:0] a, input logic bm);
		logic [7:0] b;
		b = ref_mem[bm ? a[4:0] : a[5:1]];
		return bm ? b : {4'h0, (a[0] ? b[7:4] : b[3:0])};
	endfunction : expect_rd

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			n_errors++;
		end
	endtask : check

	// write through the partner and track it in the reference copy
	task automatic do_write(input logic en, input logic [5:0] a, input logic [7:0] d);
		u_user.wr_op(en, a, d);
		if (en && cfg.byte_mode)
			ref_mem[a[4:0]] = d;
		else if (en && a[0])
			ref_mem[a[5:1]][7:4] = d[3:0];
		else if (en)
			ref_mem[a[5:1]][3:0] = d[3:0];
	endtask : do_write

	// read through the partner; a disabled read keeps the old output
	task automatic do_read(input logic en, input logic [5:0] a);
		u_user.rd_op(en, a);
		if (en)
		begin
			last_rd = expect_rd(a, cfg.byte_mode);
			last_hi = last_rd ^ (cfg.byte_mode ? 8'hff : 8'h0f);
		end
		check("read_data_out", last_rd, rdata);
		check("read_data_hi", last_hi, rdata_hi);
	endtask : do_read

	// random read or write, some with the enable low
	task automatic rnd_op();
		seed = lfsr(seed);
		if (seed[0])
			do_write(seed[1] | seed[2], seed[8:3], seed[16:9]);
		else
			do_read(seed[1] | seed[2], seed[8:3]);
	endtask : rnd_op

	task automatic give_verdict();
		if (n_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	// main sequence: fill, then every polarity and width combination
	initial
	begin
		reset_n  = 1'b0;
		cfg      = 3'b100;
		seed     = 32'ha27b;
		n_errors = 0;
		checked  = 0;
		last_rd  = 8'h00;
		last_hi  = 8'h00;
		repeat (16) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		check("read_data_out", 8'h00, rdata);
		check("read_data_hi", 8'h00, rdata_hi);
		for (int i = 0; i < 32; i++)
		begin
			seed = lfsr(seed);
			do_write(1'b1, {seed[0], 5'(i)}, seed[15:8]);
		end
		for (int c = 7; c >= 0; c--)
		begin
			@(negedge clk);
			cfg = dpr_cfg_t'(3'(c));
			repeat (4) @(negedge clk);
			for (int k = 0; k < 12; k++)
				rnd_op();
			seed = lfsr(seed);
			fork
				do_write(1'b1, seed[5:0], seed[13:6]);
				do_read(1'b1, ~seed[5:0]);
			join
			do_read(1'b1, seed[5:0]);
		end
		give_verdict();
	end

	// watchdog: about fifteen times the expected run length
	initial
	begin
		repeat (30000) @(posedge clk);
		n_errors++;
		give_verdict();
	end
endmodule : dual_port_sram_block_tb_top
